// File: design/sdrt_pkg.sv
package sdrt_pkg;
   // Register map (word offsets as byte addresses)
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] CLKCTL_OFS = 8'h04;
   localparam logic [7:0] LRLD_OFS   = 8'h08;
   localparam logic [7:0] HRLD_OFS   = 8'h0c;
   localparam logic [7:0] LCNT_OFS   = 8'h10;
   localparam logic [7:0] HCNT_OFS   = 8'h14;
   localparam logic [7:0] STAT_OFS   = 8'h18;
   localparam logic [7:0] MASK_OFS   = 8'h1c;
   // Control register fields
   localparam int CTRL_RUN_BIT   = 2;
   localparam int CTRL_SPLIT_BIT = 3;
   localparam int CTRL_CAPEN_BIT = 4;
   localparam int CTRL_LIEN_BIT  = 5;
   localparam int CTRL_XCLK_BIT  = 0;
   localparam int CTRL_TIEN_BIT  = 1;
   // Clock control fields
   localparam int CLK_LFAST_BIT = 0;
   localparam int CLK_HFAST_BIT = 1;
   // Status fields
   localparam int STAT_LOVF_BIT = 0;
   localparam int STAT_HOVF_BIT = 1;
   // Reset values
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] CLKCTL_RST = 8'h00;
   localparam logic [7:0] RLD_RST    = 8'h00;
   localparam logic [1:0] STAT_RST   = 2'h0;
   localparam logic [1:0] MASK_RST   = 2'h3;
   // Timing counts
   localparam int SYS_DIV = 12;
   localparam int EXT_DIV = 8;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } sdrt_bus_req_t;
endpackage : sdrt_pkg

// File: design/sdrt_timer.sv
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module sdrt_timer (
   input  wire logic                  ref_clk_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  clk_en_i,
   input  wire logic                  ext_clk_i,
   input  wire sdrt_pkg::sdrt_bus_req_t bus_i,
   output logic [31:0]                rdata_o,
   output logic                       irq_o
);
   logic [7:0] ctrl_reg, clkctl_reg, lrld_reg, hrld_reg, lcnt_reg, hcnt_reg;
   logic [1:0] stat_reg, mask_reg;
   logic [3:0] div_reg;
   logic [2:0] ext_sync_reg;
   logic [2:0] ext_div_reg;
   logic [31:0] rdata_reg;

   wire wr_ctrl   = bus_i.wr && bus_i.addr == sdrt_pkg::CTRL_OFS;
   wire wr_clkctl = bus_i.wr && bus_i.addr == sdrt_pkg::CLKCTL_OFS;
   wire wr_lrld   = bus_i.wr && bus_i.addr == sdrt_pkg::LRLD_OFS;
   wire wr_hrld   = bus_i.wr && bus_i.addr == sdrt_pkg::HRLD_OFS;
   wire wr_lcnt   = bus_i.wr && bus_i.addr == sdrt_pkg::LCNT_OFS;
   wire wr_hcnt   = bus_i.wr && bus_i.addr == sdrt_pkg::HCNT_OFS;
   wire wr_stat   = bus_i.wr && bus_i.addr == sdrt_pkg::STAT_OFS;
   wire wr_mask   = bus_i.wr && bus_i.addr == sdrt_pkg::MASK_OFS;

   // Clock source enables
   wire sys12_tick = (div_reg == 4'(sdrt_pkg::SYS_DIV - 1));
   wire ext_rise   = ext_sync_reg[1] && !ext_sync_reg[2];
   wire ext8_tick  = ext_rise && (ext_div_reg == 3'(sdrt_pkg::EXT_DIV - 1));
   wire slow_tick  = ctrl_reg[sdrt_pkg::CTRL_XCLK_BIT] ? ext8_tick : sys12_tick;
   wire l_tick     = clkctl_reg[sdrt_pkg::CLK_LFAST_BIT] ? 1'b1 : slow_tick;
   wire h_tick     = clkctl_reg[sdrt_pkg::CLK_HFAST_BIT] ? 1'b1 : slow_tick;

   wire split_on = ctrl_reg[sdrt_pkg::CTRL_SPLIT_BIT] && !ctrl_reg[sdrt_pkg::CTRL_CAPEN_BIT];
   wire l_inc    = split_on && l_tick;
   wire h_inc    = split_on && h_tick && ctrl_reg[sdrt_pkg::CTRL_RUN_BIT];
   wire l_ovf    = l_inc && lcnt_reg == 8'hff;
   wire h_ovf    = h_inc && hcnt_reg == 8'hff;
   wire [7:0] lcnt_next = l_ovf ? lrld_reg : lcnt_reg + 8'h01;
   wire [7:0] hcnt_next = h_ovf ? hrld_reg : hcnt_reg + 8'h01;

   // Set wins over a software clear
   wire [1:0] stat_clr  = wr_stat ? bus_i.wdata[1:0] : 2'h0;
   wire [1:0] stat_next = (stat_reg & ~stat_clr) | {h_ovf, l_ovf};

   wire       irq_src_l = ctrl_reg[sdrt_pkg::CTRL_LIEN_BIT] && stat_reg[sdrt_pkg::STAT_LOVF_BIT];
   wire       irq_src_h = stat_reg[sdrt_pkg::STAT_HOVF_BIT];
   wire [1:0] irq_pend  = {irq_src_h, irq_src_l} & ~mask_reg;
   assign irq_o = ctrl_reg[sdrt_pkg::CTRL_TIEN_BIT] && |irq_pend;

   wire [31:0] rd_mux =
      (bus_i.addr == sdrt_pkg::CTRL_OFS)   ? {24'h0, ctrl_reg} :
      (bus_i.addr == sdrt_pkg::CLKCTL_OFS) ? {24'h0, clkctl_reg} :
      (bus_i.addr == sdrt_pkg::LRLD_OFS)   ? {24'h0, lrld_reg} :
      (bus_i.addr == sdrt_pkg::HRLD_OFS)   ? {24'h0, hrld_reg} :
      (bus_i.addr == sdrt_pkg::LCNT_OFS)   ? {24'h0, lcnt_reg} :
      (bus_i.addr == sdrt_pkg::HCNT_OFS)   ? {24'h0, hcnt_reg} :
      (bus_i.addr == sdrt_pkg::STAT_OFS)   ? {30'h0, stat_reg} :
      (bus_i.addr == sdrt_pkg::MASK_OFS)   ? {30'h0, mask_reg} : 32'h0;
   assign rdata_o = rdata_reg;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         div_reg      <= 4'h0;
         ext_sync_reg <= 3'h0;
         ext_div_reg  <= 3'h0;
      end else if (clk_en_i) begin
         div_reg      <= sys12_tick ? 4'h0 : div_reg + 4'h1;
         ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_i};
         if (ext_rise) ext_div_reg <= ext_div_reg + 3'h1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ctrl_reg   <= sdrt_pkg::CTRL_RST;
         clkctl_reg <= sdrt_pkg::CLKCTL_RST;
         lrld_reg   <= sdrt_pkg::RLD_RST;
         hrld_reg   <= sdrt_pkg::RLD_RST;
         mask_reg   <= sdrt_pkg::MASK_RST;
         stat_reg   <= sdrt_pkg::STAT_RST;
         lcnt_reg   <= 8'h00;
         hcnt_reg   <= 8'h00;
         rdata_reg  <= 32'h0;
      end else if (clk_en_i) begin
         if (wr_ctrl)   ctrl_reg   <= bus_i.wdata[7:0];
         if (wr_clkctl) clkctl_reg <= bus_i.wdata[7:0];
         if (wr_lrld)   lrld_reg   <= bus_i.wdata[7:0];
         if (wr_hrld)   hrld_reg   <= bus_i.wdata[7:0];
         if (wr_mask)   mask_reg   <= bus_i.wdata[1:0];
         stat_reg <= stat_next;
         if (wr_lcnt) lcnt_reg <= bus_i.wdata[7:0];
         else if (l_inc) lcnt_reg <= lcnt_next;
         if (wr_hcnt) hcnt_reg <= bus_i.wdata[7:0];
         else if (h_inc) hcnt_reg <= hcnt_next;
         rdata_reg <= bus_i.rd ? rd_mux : 32'h0;
      end
   end

   AST_HOVF_SET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      clk_en_i && h_ovf |=> stat_reg[1]) else $error("High flag not set");
   AST_LOVF_SET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      clk_en_i && l_ovf |=> stat_reg[0]) else $error("Low flag not set");
   AST_HRELOAD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      clk_en_i && h_ovf && !wr_hcnt && !wr_hrld |=> hcnt_reg == $past(hrld_reg)) else $error("High reload missed");
   AST_LRELOAD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      clk_en_i && l_ovf && !wr_lcnt && !wr_lrld |=> lcnt_reg == $past(lrld_reg)) else $error("Low reload missed");
   AST_HSTOP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !ctrl_reg[2] && !wr_hcnt |=> $stable(hcnt_reg)) else $error("High ran while stopped");
   AST_LRUN: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      clk_en_i && split_on && clkctl_reg[0] && !wr_lcnt && lcnt_reg != 8'hff |=> lcnt_reg == $past(lcnt_reg) + 8'h01)
      else $error("Low not counting");
   AST_STICKY: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      stat_reg[1] && !(wr_stat && bus_i.wdata[1]) |=> stat_reg[1]) else $error("Flag cleared by hardware");
   AST_IRQ_H: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      ctrl_reg[1] && stat_reg[1] && !mask_reg[1] |-> irq_o) else $error("High irq missing");
   AST_IRQ_L: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !ctrl_reg[5] && !stat_reg[1] |-> !irq_o) else $error("Low irq without enable");
   AST_SLOW: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      sys12_tick && clk_en_i |=> !sys12_tick [*8]) else $error("Divider too fast");
   COV_HOVF: cover property (@(posedge ref_clk_i) h_ovf);
   COV_LOVF: cover property (@(posedge ref_clk_i) l_ovf);
   COV_BOTH: cover property (@(posedge ref_clk_i) h_ovf && l_ovf);
   COV_EXT:  cover property (@(posedge ref_clk_i) ext8_tick && l_inc);
endmodule : sdrt_timer

// File: tb/sdrt_timer_test.sv
`timescale 1ns/1ps
module sdrt_timer_test;
   localparam logic [7:0] CT = sdrt_pkg::CTRL_OFS, CK = sdrt_pkg::CLKCTL_OFS, ST = sdrt_pkg::STAT_OFS;
   localparam logic [7:0] MK = sdrt_pkg::MASK_OFS, LR = sdrt_pkg::LRLD_OFS, HR = sdrt_pkg::HRLD_OFS;
   localparam logic [7:0] LC = sdrt_pkg::LCNT_OFS, HC = sdrt_pkg::HCNT_OFS;
   localparam logic [31:0] SP = 32'h1 << sdrt_pkg::CTRL_SPLIT_BIT, RN = 32'h1 << sdrt_pkg::CTRL_RUN_BIT;
   localparam logic [31:0] TI = 32'h1 << sdrt_pkg::CTRL_TIEN_BIT, LI = 32'h1 << sdrt_pkg::CTRL_LIEN_BIT;
   localparam logic [31:0] CE = 32'h1 << sdrt_pkg::CTRL_CAPEN_BIT, XC = 32'h1 << sdrt_pkg::CTRL_XCLK_BIT;
   logic                    ref_clk_i = 1'b0;
   logic                    sys_rst_i = 1'b1;
   logic                    clk_en_i  = 1'b1;
   logic                    ext_clk_i = 1'b0;
   sdrt_pkg::sdrt_bus_req_t bus_i     = '0;
   logic [31:0]             rdata_o;
   logic                    irq_o;
   logic [31:0]             exp_q[$];
   logic                    rd_d = 1'b0;
   int                      n_mismatch = 0;
   int                      samples_checked = 0;
   int                      cyc = 0;
   logic [7:0]              rv;
   logic [31:0]             ckv[3] = '{32'h1, 32'h0, 32'h0};
   logic [31:0]             stv[3] = '{32'h1, 32'h3, 32'h3};
   logic [31:0]             xcv[3] = '{32'h0, 32'h0, XC};
   int                      early[3] = '{6, 120, 680};
   int                      late[3] = '{16, 170, 880};
   always #5 ref_clk_i = ~ref_clk_i;
   sdrt_timer u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .ext_clk_i(ext_clk_i),
                     .bus_i(bus_i), .rdata_o(rdata_o), .irq_o(irq_o));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_i);
      bus_i <= '0;
      @(posedge ref_clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_i);
      bus_i <= '0;
      @(posedge ref_clk_i);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : idle
   task automatic results;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   always @(posedge ref_clk_i) begin
      rd_d <= bus_i.rd;
      if (rd_d) chk("rdata_o", exp_q.pop_front(), rdata_o);
      cyc++;
      if (cyc > 6000) begin
         n_mismatch++;
         results();
      end
   end
   always begin
      idle(4);
      ext_clk_i <= ~ext_clk_i;
   end
   initial begin
      void'($urandom(29));
      idle(2);
      sys_rst_i <= 1'b0;
      idle(1);
      rd(CT, 32'(sdrt_pkg::CTRL_RST)); rd(CK, 32'(sdrt_pkg::CLKCTL_RST)); rd(LR, 32'(sdrt_pkg::RLD_RST));
      rd(ST, 32'(sdrt_pkg::STAT_RST)); rd(MK, 32'(sdrt_pkg::MASK_RST)); rd(8'h20, 32'h0);
      $display("reset test done");
      rv = 8'($urandom);
      wr(CK, 32'h3); wr(LR, 32'hff); wr(LC, 32'hff); wr(HC, 32'(rv)); wr(HR, 32'(~rv)); wr(CT, SP | TI); idle(4);
      rd(HC, 32'(rv));
      rd(LC, 32'hff);
      rd(ST, 32'h1);
      wr(MK, 32'h0); idle(1); chk("irq_o", 32'h0, 32'(irq_o));
      wr(CT, SP | TI | LI); idle(1); chk("irq_o", 32'h1, 32'(irq_o));
      wr(CT, TI | LI); idle(3); rd(ST, 32'h1);
      wr(ST, 32'h1); rd(ST, 32'h0); chk("irq_o", 32'h0, 32'(irq_o));
      $display("low half test done");
      wr(HR, 32'hff); wr(HC, 32'hff); wr(CT, SP | RN | TI); idle(4);
      rd(HC, 32'hff);
      rd(ST, 32'h3);
      chk("irq_o", 32'h1, 32'(irq_o));
      wr(MK, 32'h2); idle(1); chk("irq_o", 32'h0, 32'(irq_o));
      wr(CT, SP | CE); wr(ST, 32'h3); idle(4); rd(ST, 32'h0);
      $display("high half test done");
      for (int m = 0; m < 3; m++) begin
         wr(CT, xcv[m]); wr(CK, ckv[m]); wr(LR, 32'hf4); wr(LC, 32'hf4); wr(HC, 32'hf4); wr(ST, 32'h3);
         wr(CT, SP | RN | xcv[m]); idle(early[m]);
         rd(ST, 32'h0);
         idle(late[m] - early[m]);
         rd(ST, stv[m]);
      end
      $display("clock source test done");
      wr(CT, 32'h0); wr(CK, 32'h3); wr(LC, 32'h10); wr(CT, SP);
      clk_en_i <= 1'b0;
      idle(5);
      clk_en_i <= 1'b1;
      rd(LC, 32'h11);
      $display("clock enable test done");
      idle(2);
      results();
   end
endmodule : sdrt_timer_test
